// File: design/output_compare_pulse_pwm.v
// Functional notes
// - Single-pulse mode write drives pin low, arms.
// - Pulse modes: primary match drives pin high.
// - Single pulse: secondary match drives low, stays.
// - Secondary match sets flag; irq needs enable.
// - Rewriting single-pulse mode starts another pulse.
// - Continuous mode: one pulse every timer period.
// - Continuous mode: flag on every secondary match.
// - Period match restarts count at zero.
// - Timer select bit picks compared timebase.
// - PWM modes make primary read-only duty.
// - Secondary copied to primary at period match.
// - Primary preloaded gives first period duty.
// - Period value N gives N+1 counts.
// - Duty zero keeps pin low.
// - Duty above period keeps pin high.
// - Duty equal period: low one count.
// - Two PWM codes: fault enabled, ignored.
// - Read-only fault status, cleared by mode write.
// - Off, set high, set low, toggle modes.
// - Idle-halt bit stops channel in idle.
`timescale 1ns/1ps
`include "output_compare_regs.vh"

module output_compare_pulse_pwm #(
  parameter WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire idle_mode,
  input wire fault_input_pin_n,
  output reg compare_output_pin,
  output reg compare_irq
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg [2:0] compare_mode_field;
  reg compare_timer_select;
  reg idle_halt_select;
  reg pwm_fault_status;
  reg [WIDTH-1:0] compare_primary;
  reg [WIDTH-1:0] compare_secondary;
  reg compare_irq_flag;
  reg compare_irq_enable;
  reg timer_run [0:1];
  reg [1:0] timer_prescale [0:1];
  reg [WIDTH-1:0] timebase_period [0:1];
  wire [WIDTH-1:0] timebase_count [0:1];
  wire timer_step [0:1];
  reg pulse_done;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg aw_held;
  reg w_held;
  reg [31:0] next_rdata;
  reg rd_hit;

  // Returns a 16-bit word with the enabled byte lanes replaced.
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16 = old;
      if (strb[0]) merge16[7:0] = data[7:0];
      if (strb[1]) merge16[15:8] = data[15:8];
    end
  endfunction

  // True for the offsets that hold a register.
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'h0) && (addr <= `OFS_TIMER1_COUNT);
    end
  endfunction

  // ----------------------------------------------------------------
  // Two timebases
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_timer
      timebase_counter #(
        .WIDTH(WIDTH)
      ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .timer_run(timer_run[gi]),
        .prescale(timer_prescale[gi]),
        .timebase_period(timebase_period[gi]),
        .timebase_count(timebase_count[gi]),
        .step(timer_step[gi])
      );
    end
  endgenerate

  // Selected timebase seen by the comparators.
  wire [WIDTH-1:0] sel_count = compare_timer_select ?
    timebase_count[1] : timebase_count[0];
  wire [WIDTH-1:0] sel_period = compare_timer_select ?
    timebase_period[1] : timebase_period[0];
  wire sel_step = compare_timer_select ? timer_step[1] : timer_step[0];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = wr_fire && (aw_addr == `OFS_COMPARE_CONTROL);
  wire mode_wr = wr_ctrl && w_strb[0];
  wire [2:0] new_mode = w_data[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire pwm_mode = (compare_mode_field == `MODE_PWM) ||
    (compare_mode_field == `MODE_PWM_FAULT);

  // Address and data are taken in either order and held until used.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Software-written configuration registers.
  always @(posedge aclk) begin
    if (!aresetn) begin
      compare_mode_field <= `MODE_OFF;
      compare_timer_select <= 1'b0;
      idle_halt_select <= 1'b0;
      compare_secondary <= `RST_WORD16;
      compare_irq_enable <= 1'b0;
      timer_run[0] <= 1'b0;
      timer_run[1] <= 1'b0;
      timer_prescale[0] <= 2'h0;
      timer_prescale[1] <= 2'h0;
      timebase_period[0] <= `RST_PERIOD;
      timebase_period[1] <= `RST_PERIOD;
    end else if (wr_fire) begin
      case (aw_addr)
        `OFS_COMPARE_CONTROL: begin
          if (w_strb[0]) begin
            compare_mode_field <= new_mode;
            compare_timer_select <= w_data[`CTRL_TSEL_BIT];
          end
          if (w_strb[1]) begin
            idle_halt_select <= w_data[`CTRL_IDLE_BIT];
          end
        end
        `OFS_COMPARE_SECONDARY: begin
          compare_secondary <= merge16(compare_secondary, w_data,
            w_strb);
        end
        `OFS_IRQ_STATUS: begin
          if (w_strb[0]) begin
            compare_irq_enable <= w_data[`IRQ_ENABLE_BIT];
          end
        end
        `OFS_TIMER0_CONTROL: begin
          if (w_strb[0]) begin
            timer_prescale[0] <=
              w_data[`TMR_PRESCALE_MSB:`TMR_PRESCALE_LSB];
          end
          if (w_strb[1]) begin
            timer_run[0] <= w_data[`TMR_RUN_BIT];
          end
        end
        `OFS_TIMER0_PERIOD: begin
          timebase_period[0] <= merge16(timebase_period[0], w_data,
            w_strb);
        end
        `OFS_TIMER1_CONTROL: begin
          if (w_strb[0]) begin
            timer_prescale[1] <=
              w_data[`TMR_PRESCALE_MSB:`TMR_PRESCALE_LSB];
          end
          if (w_strb[1]) begin
            timer_run[1] <= w_data[`TMR_RUN_BIT];
          end
        end
        `OFS_TIMER1_PERIOD: begin
          timebase_period[1] <= merge16(timebase_period[1], w_data,
            w_strb);
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Compare channel
  // ----------------------------------------------------------------
  wire halted = idle_halt_select && idle_mode;
  wire active = !halted && (compare_mode_field != `MODE_OFF);
  wire ev = active && sel_step;
  wire hit_primary = ev && (sel_count == compare_primary);
  wire hit_secondary = ev && (sel_count == compare_secondary);
  wire period_hit = ev && (sel_count == sel_period);
  wire fault_now = !halted && !fault_input_pin_n &&
    (compare_mode_field == `MODE_PWM_FAULT);
  wire pulse_mode = (compare_mode_field == `MODE_SINGLE) ||
    (compare_mode_field == `MODE_CONT);
  wire flag_set = (pulse_mode && hit_secondary && !pulse_done) ||
    (compare_mode_field == `MODE_SET_HIGH && hit_primary) ||
    (compare_mode_field == `MODE_SET_LOW && hit_primary) ||
    (compare_mode_field == `MODE_TOGGLE && hit_primary) ||
    (fault_now && !pwm_fault_status);
  wire flag_clr = wr_fire && (aw_addr == `OFS_IRQ_STATUS) &&
    w_strb[0] && w_data[`IRQ_FLAG_BIT];

  // Duty register: software copy outside PWM, buffered load inside.
  always @(posedge aclk) begin
    if (!aresetn) begin
      compare_primary <= `RST_WORD16;
    end else if (pwm_mode && period_hit) begin
      compare_primary <= compare_secondary;
    end else if (wr_fire && !pwm_mode &&
                 aw_addr == `OFS_COMPARE_PRIMARY) begin
      compare_primary <= merge16(compare_primary, w_data,
        w_strb);
    end
  end

  // Pin level, pulse completion and fault status.
  always @(posedge aclk) begin
    if (!aresetn) begin
      compare_output_pin <= 1'b0;
      pulse_done <= 1'b0;
      pwm_fault_status <= 1'b0;
    end else if (mode_wr) begin
      compare_output_pin <= (new_mode == `MODE_SET_LOW);
      pulse_done <= 1'b0;
      pwm_fault_status <= 1'b0;
    end else if (fault_now || pwm_fault_status) begin
      compare_output_pin <= 1'b0;
      pwm_fault_status <= pwm_fault_status ||
        (compare_mode_field == `MODE_PWM_FAULT);
    end else if (ev) begin
      case (compare_mode_field)
        `MODE_SET_HIGH: begin
          if (hit_primary) compare_output_pin <= 1'b1;
        end
        `MODE_SET_LOW: begin
          if (hit_primary) compare_output_pin <= 1'b0;
        end
        `MODE_TOGGLE: begin
          if (hit_primary) compare_output_pin <= !compare_output_pin;
        end
        `MODE_SINGLE, `MODE_CONT: begin
          if (!pulse_done) begin
            if (hit_secondary) begin
              compare_output_pin <= 1'b0;
              pulse_done <= (compare_mode_field == `MODE_SINGLE);
            end else if (hit_primary) begin
              compare_output_pin <= 1'b1;
            end
          end
        end
        `MODE_PWM, `MODE_PWM_FAULT: begin
          if (sel_count == compare_primary) begin
            compare_output_pin <= 1'b0;
          end else if (sel_count == {WIDTH{1'b0}}) begin
            compare_output_pin <= 1'b1;
          end
        end
        default: begin
          compare_output_pin <= 1'b0;
        end
      endcase
    end
  end

  // Sticky flag: a set in the clearing cycle wins; enable gates the line.
  always @(posedge aclk) begin
    if (!aresetn) begin
      compare_irq_flag <= 1'b0;
      compare_irq <= 1'b0;
    end else begin
      compare_irq_flag <= (compare_irq_flag && !flag_clr) ||
        flag_set;
      compare_irq <= (compare_irq_flag || flag_set) &&
        compare_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_COMPARE_CONTROL: begin
        next_rdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = compare_mode_field;
        next_rdata[`CTRL_TSEL_BIT] = compare_timer_select;
        next_rdata[`CTRL_FAULT_BIT] = pwm_fault_status;
        next_rdata[`CTRL_IDLE_BIT] = idle_halt_select;
      end
      `OFS_COMPARE_PRIMARY: next_rdata[15:0] = compare_primary;
      `OFS_COMPARE_SECONDARY: next_rdata[15:0] = compare_secondary;
      `OFS_IRQ_STATUS: begin
        next_rdata[`IRQ_FLAG_BIT] = compare_irq_flag;
        next_rdata[`IRQ_ENABLE_BIT] = compare_irq_enable;
      end
      `OFS_TIMER0_CONTROL: begin
        next_rdata[`TMR_RUN_BIT] = timer_run[0];
        next_rdata[`TMR_PRESCALE_MSB:`TMR_PRESCALE_LSB] =
          timer_prescale[0];
      end
      `OFS_TIMER0_PERIOD: next_rdata[15:0] = timebase_period[0];
      `OFS_TIMER0_COUNT: next_rdata[15:0] = timebase_count[0];
      `OFS_TIMER1_CONTROL: begin
        next_rdata[`TMR_RUN_BIT] = timer_run[1];
        next_rdata[`TMR_PRESCALE_MSB:`TMR_PRESCALE_LSB] =
          timer_prescale[1];
      end
      `OFS_TIMER1_PERIOD: next_rdata[15:0] = timebase_period[1];
      `OFS_TIMER1_COUNT: next_rdata[15:0] = timebase_count[1];
      default: rd_hit = 1'b0;
    endcase
  end

  // One read at a time; data is answered one cycle after the address.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // output_compare_pulse_pwm

// File: design/output_compare_regs.vh
`ifndef OUTPUT_COMPARE_REGS_VH
`define OUTPUT_COMPARE_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_COMPARE_CONTROL 8'h00
`define OFS_COMPARE_PRIMARY 8'h04
`define OFS_COMPARE_SECONDARY 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_TIMER0_CONTROL 8'h10
`define OFS_TIMER0_PERIOD 8'h14
`define OFS_TIMER0_COUNT 8'h18
`define OFS_TIMER1_CONTROL 8'h1C
`define OFS_TIMER1_PERIOD 8'h20
`define OFS_TIMER1_COUNT 8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_MODE_MSB 2
`define CTRL_MODE_LSB 0
`define CTRL_TSEL_BIT 3
`define CTRL_FAULT_BIT 4
`define CTRL_IDLE_BIT 13
`define IRQ_FLAG_BIT 0
`define IRQ_ENABLE_BIT 1
`define TMR_RUN_BIT 15
`define TMR_PRESCALE_MSB 5
`define TMR_PRESCALE_LSB 4

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define MODE_OFF 3'h0
`define MODE_SET_HIGH 3'h1
`define MODE_SET_LOW 3'h2
`define MODE_TOGGLE 3'h3
`define MODE_SINGLE 3'h4
`define MODE_CONT 3'h5
`define MODE_PWM 3'h6
`define MODE_PWM_FAULT 3'h7

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define RST_WORD16 16'h0000
`define RST_PERIOD 16'hFFFF
`define PRESCALE_1 8'h00
`define PRESCALE_8 8'h07
`define PRESCALE_64 8'h3F
`define PRESCALE_256 8'hFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: design/timebase_counter.v
`timescale 1ns/1ps
`include "output_compare_regs.vh"

module timebase_counter #(
  parameter WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire timer_run,
  input wire [1:0] prescale,
  input wire [WIDTH-1:0] timebase_period,
  output reg [WIDTH-1:0] timebase_count,
  output reg step
);

  reg [7:0] div;
  reg [7:0] div_limit;

  // Prescale ratio 1, 8, 64 or 256 as a terminal count of the divider.
  always @* begin
    case (prescale)
      2'h0: div_limit = `PRESCALE_1;
      2'h1: div_limit = `PRESCALE_8;
      2'h2: div_limit = `PRESCALE_64;
      default: div_limit = `PRESCALE_256;
    endcase
  end

  // Count advances once per prescaled tick; step marks a fresh count.
  always @(posedge aclk) begin
    if (!aresetn) begin
      div <= 8'h00;
      timebase_count <= {WIDTH{1'b0}};
      step <= 1'b0;
    end else begin
      step <= 1'b0;
      if (timer_run) begin
        if (div >= div_limit) begin
          div <= 8'h00;
          step <= 1'b1;
          if (timebase_count == timebase_period) begin
            timebase_count <= {WIDTH{1'b0}};
          end else begin
            timebase_count <= timebase_count + 1'b1;
          end
        end else begin
          div <= div + 8'h01;
        end
      end
    end
  end

endmodule // timebase_counter

// File: verif/output_compare_pulse_pwm_assertions.sv
`timescale 1ns/1ps
`include "output_compare_regs.vh"

module output_compare_pulse_pwm_assertions (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire fault_input_pin_n,
  input wire compare_output_pin,
  input wire compare_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // Write tracking
  // ------------------------------------------------------------
  reg [7:0] wa;
  reg [31:0] wd;
  reg [3:0] ws;
  reg [2:0] md;
  reg en;
  reg bv;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire b_new = s_axi_bvalid && !bv && s_axi_bresp == `RESP_OKAY;

  // Holds the last write and mirrors the mode and enable fields.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wa <= 8'h00;
      wd <= 32'h0;
      ws <= 4'h0;
      md <= 3'h0;
      en <= 1'h0;
      bv <= 1'h0;
    end else begin
      bv <= s_axi_bvalid;
      if (aw_hs) begin
        wa <= s_axi_awaddr;
      end
      if (w_hs) begin
        wd <= s_axi_wdata;
        ws <= s_axi_wstrb;
      end
      if (b_new && ws[0] && wa == `OFS_COMPARE_CONTROL) begin
        md <= wd[2:0];
      end
      if (b_new && ws[0] && wa == `OFS_IRQ_STATUS) begin
        en <= wd[1];
      end
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_mode(logic [2:0] m);
    $rose(s_axi_bvalid) && ws[0] && wa == `OFS_COMPARE_CONTROL &&
      wd[2:0] == m;
  endsequence

  sequence s_fault;
    md == `MODE_PWM_FAULT && !fault_input_pin_n && !s_axi_bvalid;
  endsequence

  chk_single_init_low: assert property (s_mode(`MODE_SINGLE) |->
    !compare_output_pin) else $error("pin not low after single mode");
  chk_cont_init_low: assert property (s_mode(`MODE_CONT) |->
    !compare_output_pin) else $error("pin not low after pulse mode");
  chk_force_low_init: assert property (s_mode(`MODE_SET_LOW) |->
    compare_output_pin) else $error("pin not high after force low mode");
  chk_irq_enable: assert property (compare_irq |->
    en || $past(en)) else $error("interrupt without enable");
  chk_fault_low: assert property (s_fault ##1
    (md == `MODE_PWM_FAULT && !s_axi_bvalid) [*3] |-> !compare_output_pin)
    else $error("pin not forced low by fault");
  chk_write_answer: assert property (aw_hs && w_hs |=>
    !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  chk_write_release: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not released");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  chk_unmapped_err: assert property ($rose(s_axi_bvalid) &&
    (wa > `OFS_TIMER1_COUNT || wa[1:0] != 2'h0) |->
    s_axi_bresp == `RESP_SLVERR) else $error("unmapped write accepted");
endmodule // output_compare_pulse_pwm_assertions

bind output_compare_pulse_pwm output_compare_pulse_pwm_assertions i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .fault_input_pin_n(fault_input_pin_n),
  .compare_output_pin(compare_output_pin), .compare_irq(compare_irq)
);

// File: verif/tb_top.sv
`timescale 1ns/1ps
`include "output_compare_regs.vh"

module tb_top;
  logic aclk, aresetn, idle_mode, fault_input_pin_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, compare_output_pin, compare_irq;
  int n_errors, n_checks, hi, rises, gap;
  logic [31:0] duty [3] = '{32'h0, 32'hA, 32'h9};
  logic [31:0] full [3] = '{32'h0, 32'h1E, 32'h1B};

  output_compare_pulse_pwm #(.WIDTH(16)) i_output_compare_pulse_pwm (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .idle_mode(idle_mode), .fault_input_pin_n(fault_input_pin_n),
    .compare_output_pin(compare_output_pin), .compare_irq(compare_irq)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bus write; a stray edge first keeps back-to-back calls apart.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = `RESP_OKAY);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check_word({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  // Bus read with comparison of data and response.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er = `RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    check_word(s_axi_rdata, exp);
    check_word({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // Counts high cycles, rising edges and the last gap between rises.
  task automatic watch(input int n);
    int last;
    logic p;
    hi = 0;
    rises = 0;
    gap = 0;
    last = 0;
    p = compare_output_pin;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (compare_output_pin === 1'h1) begin
        hi++;
      end
      if (compare_output_pin === 1'h1 && p === 1'h0) begin
        gap = (rises > 0) ? i - last : 0;
        last = i;
        rises++;
      end
      p = compare_output_pin;
    end
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  // A hang ends the run as a failure.
  initial begin
    #200000;
    n_errors++;
    test_done();
  end

  initial begin
    {aresetn, idle_mode, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    fault_input_pin_n = 1'h1;
    n_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(`OFS_COMPARE_CONTROL, 32'h0);
    rdc(`OFS_TIMER0_PERIOD, 32'hFFFF);
    rdc(8'h28, 32'h0, `RESP_SLVERR);
    rdc(8'h06, 32'h0, `RESP_SLVERR);
    wr(8'h30, 32'h1, `RESP_SLVERR);
    wr(`OFS_COMPARE_PRIMARY, 32'h2);
    wr(`OFS_COMPARE_SECONDARY, 32'h5);
    wr(`OFS_TIMER1_PERIOD, 32'h8);
    wr(`OFS_IRQ_STATUS, 32'h2);
    wr(`OFS_COMPARE_CONTROL, 32'hC);
    check_word({31'h0, compare_output_pin}, 32'h0);
    wr(`OFS_TIMER1_CONTROL, 32'h8000);
    watch(40);
    check_word(rises, 32'h1);
    check_word(hi, 32'h3);
    check_word({31'h0, compare_irq}, 32'h1);
    rdc(`OFS_IRQ_STATUS, 32'h3);
    wr(`OFS_IRQ_STATUS, 32'h1);
    fork
      watch(40);
      wr(`OFS_COMPARE_CONTROL, 32'hC);
    join
    check_word(rises, 32'h1);
    check_word({31'h0, compare_irq}, 32'h0);
    rdc(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_TIMER1_CONTROL, 32'h0);
    wr(`OFS_TIMER0_PERIOD, 32'h9);
    wr(`OFS_COMPARE_CONTROL, 32'h5);
    wr(`OFS_TIMER0_CONTROL, 32'h8000);
    watch(40);
    check_word(hi, 32'hC);
    check_word(gap, 32'hA);
    for (int k = 0; k < 2; k++) begin
      wr(`OFS_IRQ_STATUS, 32'h1);
      watch(12);
      rdc(`OFS_IRQ_STATUS, 32'h1);
    end
    wr(`OFS_COMPARE_CONTROL, 32'h0);
    wr(`OFS_COMPARE_PRIMARY, 32'h4);
    wr(`OFS_COMPARE_SECONDARY, 32'h4);
    wr(`OFS_COMPARE_CONTROL, 32'h6);
    watch(10);
    watch(30);
    check_word(hi, 32'hC);
    check_word(gap, 32'hA);
    wr(`OFS_COMPARE_PRIMARY, 32'h7);
    rdc(`OFS_COMPARE_PRIMARY, 32'h4);
    for (int k = 0; k < 3; k++) begin
      idle_mode <= (k == 2);
      wr(`OFS_COMPARE_SECONDARY, duty[k]);
      watch(12);
      rdc(`OFS_COMPARE_PRIMARY, duty[k]);
      watch(30);
      check_word(hi, full[k]);
    end
    idle_mode <= 1'h0;
    fault_input_pin_n <= 1'h0;
    watch(30);
    check_word(hi, 32'h1B);
    fault_input_pin_n <= 1'h1;
    wr(`OFS_IRQ_STATUS, 32'h3);
    wr(`OFS_COMPARE_CONTROL, 32'h7);
    fault_input_pin_n <= 1'h0;
    repeat (3) @(posedge aclk);
    fault_input_pin_n <= 1'h1;
    watch(30);
    check_word(hi, 32'h0);
    rdc(`OFS_COMPARE_CONTROL, 32'h17);
    wr(`OFS_COMPARE_CONTROL, 32'h17);
    rdc(`OFS_COMPARE_CONTROL, 32'h7);
    watch(10);
    watch(30);
    check_word(hi, 32'h1B);
    idle_mode <= 1'h1;
    wr(`OFS_COMPARE_CONTROL, 32'h2006);
    watch(30);
    check_word(rises, 32'h0);
    idle_mode <= 1'h0;
    watch(30);
    check_word(rises, 32'h3);
    wr(`OFS_COMPARE_CONTROL, 32'h0);
    wr(`OFS_COMPARE_PRIMARY, 32'h3);
    for (int k = 1; k < 3; k++) begin
      wr(`OFS_COMPARE_CONTROL, k);
      check_word({31'h0, compare_output_pin}, k - 1);
      watch(20);
      check_word({31'h0, compare_output_pin}, 2 - k);
    end
    wr(`OFS_COMPARE_CONTROL, 32'h3);
    watch(40);
    check_word(hi, 32'h14);
    check_word(gap, 32'h14);
    test_done();
  end
endmodule // tb_top
